// ### design/atp_pattern_gen.sv
/*
 * One channel of the test pattern generator: passes, ramps or holds.
 * Assumes advance pulses once per sample taken into the output path.
 */
`timescale 1ns/1ps
module atp_pattern_gen import atp_pkg::*; #(
    parameter int RES_W = ATP_RES_W
) (
    input wire logic mclk,
    input wire logic reset,
    input wire atp_mode_t mode,
    input wire logic [RES_W-1:0] user_value,
    input wire logic [RES_W-1:0] sample,
    input wire logic advance,
    output logic [RES_W-1:0] word_out
);

    logic [RES_W-1:0] ramp_reg;
    logic [RES_W-1:0] ramp_next;
    wire ramp_on = (mode == PAT_RAMP);

    // step per sample
    // natural wrap of the sum gives modulo native resolution
    assign ramp_next = !ramp_on ? '0 : (advance ? RES_W'(ramp_reg + user_value) : ramp_reg);

    always_ff @(posedge mclk) begin
        if (reset) begin
            ramp_reg <= '0;
        end else begin
            ramp_reg <= ramp_next;
        end
    end

    // native-width injection
    // word is full width and MSB aligned, the mapper downstream trims it
    assign word_out = atp_select_word(mode, sample, user_value, ramp_reg);

    property p_ramp_step;
        @(posedge mclk) disable iff (reset)
        (advance && ramp_on) ##1 ramp_on |-> word_out == RES_W'($past(word_out) + $past(user_value));
    endproperty
    a_ramp_step: assert property (p_ramp_step) else $error("ramp did not advance by step");

    property p_const_word;
        @(posedge mclk) disable iff (reset)
        (mode == PAT_CONST) |-> word_out == user_value;
    endproperty
    a_const_word: assert property (p_const_word) else $error("constant pattern not user value");

endmodule

// ### design/atp_pkg.sv
/*
 * Shared constants, types and helpers of the converter test pattern and
 * configuration register group.
 * Assumes an 8-bit register port already deserialised from the serial link.
 */
package atp_pkg;

    localparam int ATP_ADDR_W = 8;
    localparam int ATP_DATA_W = 8;
    localparam int ATP_RES_W = 18;

    localparam logic [7:0] OFS_SAMPLING = 8'h11;
    localparam logic [7:0] OFS_FUSE = 8'h13;
    localparam logic [7:0] OFS_PAT_LOW = 8'h14;
    localparam logic [7:0] OFS_PAT_MID = 8'h15;
    localparam logic [7:0] OFS_PAT_SEL_HIGH = 8'h16;
    localparam logic [7:0] OFS_FRAME = 8'h19;

    localparam int BIT_DELAY_LOOP_PDN = 2;
    localparam int BIT_AUTOZERO = 0;
    localparam int BIT_FUSE_LOAD = 0;
    localparam int PAT_B_MSB = 7;
    localparam int PAT_B_LSB = 5;
    localparam int PAT_A_MSB = 4;
    localparam int PAT_A_LSB = 2;
    localparam int PAT_HIGH_MSB = 1;
    localparam int BIT_FRAME_CLOCK_SOURCE = 7;
    localparam int BIT_FRAME_CLOCK_DIVIDE = 4;
    localparam int BIT_FCLK_STRETCH = 0;

    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    typedef logic [2:0] atp_mode_t;
    localparam atp_mode_t PAT_NORMAL = 3'h0;
    localparam atp_mode_t PAT_RAMP = 3'h2;
    localparam atp_mode_t PAT_CONST = 3'h3;

    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [ATP_ADDR_W-1:0] addr;
        logic [ATP_DATA_W-1:0] wdata;
    } atp_regreq_s;

    typedef struct packed {
        logic [ATP_RES_W-1:0] chan_a;
        logic [ATP_RES_W-1:0] chan_b;
    } atp_pair_s;

    // unused codes fall back to the converter output
    function automatic logic [ATP_RES_W-1:0] atp_select_word(input atp_mode_t mode,
            input logic [ATP_RES_W-1:0] sample, input logic [ATP_RES_W-1:0] user,
            input logic [ATP_RES_W-1:0] ramp);
        case (mode)
            PAT_RAMP: atp_select_word = ramp;
            PAT_CONST: atp_select_word = user;
            default: atp_select_word = sample;
        endcase
    endfunction

endpackage

// ### design/atp_test_pattern_regs.sv
/*
 * Configuration registers and test pattern insertion of the converter core.
 * Assumes a deserialised register port, one request per cycle, and sample
 * pairs arriving synchronous to mclk ahead of the output bit mapper.
 */
`timescale 1ns/1ps
module atp_test_pattern_regs import atp_pkg::*; #(
    // arbitrary default: 0 selects the lower-rate auto-zero polarity
    parameter bit HIGH_RATE_VARIANT = 1'b0,
    parameter int RES_W = ATP_RES_W
) (
    input wire logic mclk,
    input wire logic reset,
    input wire atp_regreq_s reg_req,
    output logic [ATP_DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic sample_valid,
    output logic sample_ready,
    input wire atp_pair_s sample_in,
    output logic out_valid,
    input wire logic out_ready,
    output atp_pair_s out_data,
    output logic sampling_delay_loop_powerdown,
    output logic sampling_window_quarter,
    output logic offset_autozero_enable,
    output logic frame_clock_source,
    output logic frame_clock_divide,
    output logic frame_clock_stretch,
    output logic fuse_map_load
);

    ////////////////////////////////////////////////////////////////////////////
    // register decode

    logic sampling_delay_loop_powerdown_reg;
    logic autozero_bit_reg;
    logic fuse_load_reg;
    logic [7:0] pat_low_reg;
    logic [7:0] pat_mid_reg;
    logic [PAT_HIGH_MSB:0] pat_high_reg;
    atp_mode_t chan_a_pattern_select;
    atp_mode_t chan_b_pattern_select;
    logic frame_clock_source_reg;
    logic frame_clock_divide_reg;
    logic fclk_stretch_reg;
    logic fuse_pulse_reg;
    logic [ATP_DATA_W-1:0] rdata_reg;
    logic rvalid_reg;

    wire wr_sampling = reg_req.wr_en && (reg_req.addr == OFS_SAMPLING);
    wire wr_fuse = reg_req.wr_en && (reg_req.addr == OFS_FUSE);
    wire wr_pat_low = reg_req.wr_en && (reg_req.addr == OFS_PAT_LOW);
    wire wr_pat_mid = reg_req.wr_en && (reg_req.addr == OFS_PAT_MID);
    wire wr_pat_sel = reg_req.wr_en && (reg_req.addr == OFS_PAT_SEL_HIGH);
    wire wr_frame = reg_req.wr_en && (reg_req.addr == OFS_FRAME);

    // release clears writes
    // the load takes effect when the bit goes back to zero
    wire fuse_release = wr_fuse && fuse_load_reg && !reg_req.wdata[BIT_FUSE_LOAD];
    wire clear_all = reset || fuse_release;

    ////////////////////////////////////////////////////////////////////////////
    // register storage; reserved bits are never stored

    always_ff @(posedge mclk) begin
        if (clear_all) begin
            sampling_delay_loop_powerdown_reg <= REG_RESET[BIT_DELAY_LOOP_PDN];
            autozero_bit_reg <= REG_RESET[BIT_AUTOZERO];
        end else if (wr_sampling) begin
            sampling_delay_loop_powerdown_reg <= reg_req.wdata[BIT_DELAY_LOOP_PDN];
            autozero_bit_reg <= reg_req.wdata[BIT_AUTOZERO];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            fuse_load_reg <= REG_RESET[BIT_FUSE_LOAD];
        end else if (wr_fuse) begin
            fuse_load_reg <= reg_req.wdata[BIT_FUSE_LOAD];
        end
    end

    always_ff @(posedge mclk) begin
        if (clear_all) begin
            pat_low_reg <= REG_RESET;
            pat_mid_reg <= REG_RESET;
            pat_high_reg <= REG_RESET[PAT_HIGH_MSB:0];
        end else begin
            if (wr_pat_low) begin
                pat_low_reg <= reg_req.wdata;
            end
            if (wr_pat_mid) begin
                pat_mid_reg <= reg_req.wdata;
            end
            if (wr_pat_sel) begin
                pat_high_reg <= reg_req.wdata[PAT_HIGH_MSB:0];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (clear_all) begin
            chan_b_pattern_select <= PAT_NORMAL;
            chan_a_pattern_select <= PAT_NORMAL;
        end else if (wr_pat_sel) begin
            chan_b_pattern_select <= reg_req.wdata[PAT_B_MSB:PAT_B_LSB];
            chan_a_pattern_select <= reg_req.wdata[PAT_A_MSB:PAT_A_LSB];
        end
    end

    always_ff @(posedge mclk) begin
        if (clear_all) begin
            frame_clock_source_reg <= REG_RESET[BIT_FRAME_CLOCK_SOURCE];
            frame_clock_divide_reg <= REG_RESET[BIT_FRAME_CLOCK_DIVIDE];
            fclk_stretch_reg <= REG_RESET[BIT_FCLK_STRETCH];
        end else if (wr_frame) begin
            frame_clock_source_reg <= reg_req.wdata[BIT_FRAME_CLOCK_SOURCE];
            frame_clock_divide_reg <= reg_req.wdata[BIT_FRAME_CLOCK_DIVIDE];
            fclk_stretch_reg <= reg_req.wdata[BIT_FCLK_STRETCH];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            fuse_pulse_reg <= 1'b0;
        end else begin
            fuse_pulse_reg <= fuse_release;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control outputs

    assign sampling_delay_loop_powerdown = sampling_delay_loop_powerdown_reg;
    assign sampling_window_quarter = !sampling_delay_loop_powerdown_reg;
    assign offset_autozero_enable = HIGH_RATE_VARIANT ? autozero_bit_reg : !autozero_bit_reg;
    assign frame_clock_source = frame_clock_source_reg;
    assign frame_clock_divide = frame_clock_divide_reg;
    assign frame_clock_stretch = fclk_stretch_reg;
    assign fuse_map_load = fuse_pulse_reg;

    ////////////////////////////////////////////////////////////////////////////
    // read back

    wire [ATP_DATA_W-1:0] rd_sampling = {5'h00, sampling_delay_loop_powerdown_reg, 1'b0, autozero_bit_reg};
    wire [ATP_DATA_W-1:0] rd_fuse = {7'h00, fuse_load_reg};
    wire [ATP_DATA_W-1:0] rd_pat_sel = {chan_b_pattern_select, chan_a_pattern_select, pat_high_reg};
    wire [ATP_DATA_W-1:0] rd_frame = {frame_clock_source_reg, 2'h0, frame_clock_divide_reg, 3'h0, fclk_stretch_reg};
    wire [ATP_DATA_W-1:0] rd_mux =
        (reg_req.addr == OFS_SAMPLING) ? rd_sampling :
        (reg_req.addr == OFS_FUSE) ? rd_fuse :
        (reg_req.addr == OFS_PAT_LOW) ? pat_low_reg :
        (reg_req.addr == OFS_PAT_MID) ? pat_mid_reg :
        (reg_req.addr == OFS_PAT_SEL_HIGH) ? rd_pat_sel :
        (reg_req.addr == OFS_FRAME) ? rd_frame : UNMAPPED_READ;

    always_ff @(posedge mclk) begin
        if (reset) begin
            rdata_reg <= REG_RESET;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg <= reg_req.rd_en ? rd_mux : rdata_reg;
            rvalid_reg <= reg_req.rd_en;
        end
    end

    assign reg_rdata = rdata_reg;
    assign reg_rvalid = rvalid_reg;

    ////////////////////////////////////////////////////////////////////////////
    // pattern insertion and output buffering

    wire [RES_W-1:0] user_pattern_value = {pat_high_reg, pat_mid_reg, pat_low_reg};
    wire sample_take = sample_valid && sample_ready;
    logic [RES_W-1:0] word_a;
    logic [RES_W-1:0] word_b;
    atp_pair_s pattern_pair;

    // format independent
    // no output format input reaches this path, so every format sees it alike
    atp_pattern_gen #(.RES_W(RES_W)) u_gen_a (
        .mclk(mclk),
        .reset(reset),
        .mode(chan_a_pattern_select),
        .user_value(user_pattern_value),
        .sample(sample_in.chan_a),
        .advance(sample_take),
        .word_out(word_a)
    );

    atp_pattern_gen #(.RES_W(RES_W)) u_gen_b (
        .mclk(mclk),
        .reset(reset),
        .mode(chan_b_pattern_select),
        .user_value(user_pattern_value),
        .sample(sample_in.chan_b),
        .advance(sample_take),
        .word_out(word_b)
    );

    // one driver for the whole pair keeps the buffer input a single net
    assign pattern_pair = '{chan_a: word_a, chan_b: word_b};

    // a stall downstream backs up into sample_ready instead of dropping pairs
    atp_two_entry_buf #(.WIDTH($bits(atp_pair_s))) u_out_buf (
        .mclk(mclk),
        .reset(reset),
        .in_valid(sample_valid),
        .in_ready(sample_ready),
        .in_data(pattern_pair),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(out_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_fuse_arm;
        wr_fuse && reg_req.wdata[BIT_FUSE_LOAD];
    endsequence

    sequence s_fuse_drop;
        wr_fuse && !reg_req.wdata[BIT_FUSE_LOAD];
    endsequence

    property p_fuse_clear;
        @(posedge mclk) disable iff (reset)
        s_fuse_arm ##[1:8] s_fuse_drop |=> fuse_map_load && user_pattern_value == '0
            && chan_a_pattern_select == PAT_NORMAL && !frame_clock_source && !sampling_delay_loop_powerdown;
    endproperty
    a_fuse_clear: assert property (p_fuse_clear) else $error("fuse load did not clear registers");

    property p_fuse_pulse;
        @(posedge mclk) disable iff (reset)
        fuse_map_load |=> !fuse_map_load;
    endproperty
    a_fuse_pulse: assert property (p_fuse_pulse) else $error("fuse load strobe longer than one cycle");

    property p_window;
        @(posedge mclk) disable iff (reset)
        wr_sampling |=> sampling_window_quarter == !$past(reg_req.wdata[BIT_DELAY_LOOP_PDN])
            && sampling_delay_loop_powerdown == $past(reg_req.wdata[BIT_DELAY_LOOP_PDN]);
    endproperty
    a_window: assert property (p_window) else $error("sampling window does not follow write");

    property p_autozero;
        @(posedge mclk) disable iff (reset)
        wr_sampling |=> offset_autozero_enable == (HIGH_RATE_VARIANT ? $past(reg_req.wdata[BIT_AUTOZERO])
            : !$past(reg_req.wdata[BIT_AUTOZERO]));
    endproperty
    a_autozero: assert property (p_autozero) else $error("auto-zero polarity wrong");

    property p_const_a;
        @(posedge mclk) disable iff (reset)
        (sample_take && !out_valid && chan_a_pattern_select == PAT_CONST)
            |=> out_valid && out_data.chan_a == $past(user_pattern_value);
    endproperty
    a_const_a: assert property (p_const_a) else $error("channel A constant pattern wrong");

    property p_normal_b;
        @(posedge mclk) disable iff (reset)
        (sample_take && !out_valid && chan_b_pattern_select == PAT_NORMAL)
            |=> out_valid && out_data.chan_b == $past(sample_in.chan_b);
    endproperty
    a_normal_b: assert property (p_normal_b) else $error("channel B normal output altered");

    property p_frame_src;
        @(posedge mclk) disable iff (reset)
        wr_frame |=> frame_clock_source == $past(reg_req.wdata[BIT_FRAME_CLOCK_SOURCE]);
    endproperty
    a_frame_src: assert property (p_frame_src) else $error("frame clock source not taken");

    property p_read_sel;
        @(posedge mclk) disable iff (reset)
        (reg_req.rd_en && reg_req.addr == OFS_PAT_SEL_HIGH)
            |=> reg_rvalid && reg_rdata == {$past(chan_b_pattern_select), $past(chan_a_pattern_select),
            $past(user_pattern_value[RES_W-1:RES_W-2])};
    endproperty
    a_read_sel: assert property (p_read_sel) else $error("select register read back wrong");

endmodule

// ### design/atp_two_entry_buf.sv
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes the drain side may hold out_ready low for any time.
 */
`timescale 1ns/1ps
module atp_two_entry_buf #(
    parameter int WIDTH = 36
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    logic [1:0] count_reg;
    logic [1:0] count_next;
    logic [WIDTH-1:0] head_reg;
    logic [WIDTH-1:0] head_next;
    logic [WIDTH-1:0] tail_reg;
    logic [WIDTH-1:0] tail_next;

    assign in_ready = (count_reg != 2'h2);
    assign out_valid = (count_reg != 2'h0);
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // head always holds the oldest word so the output is a flop
    assign head_next = (count_reg == 2'h2 && pop) ? tail_reg :
                       (push && (count_reg == 2'h0 || pop)) ? in_data : head_reg;
    assign tail_next = (push && !pop && count_reg == 2'h1) ? in_data : tail_reg;
    assign count_next = 2'(count_reg + {1'b0, push} - {1'b0, pop});

    always_ff @(posedge mclk) begin
        if (reset) begin
            count_reg <= 2'h0;
            head_reg <= '0;
            tail_reg <= '0;
        end else begin
            count_reg <= count_next;
            head_reg <= head_next;
            tail_reg <= tail_next;
        end
    end

    assign out_data = head_reg;

    property p_hold_stall;
        @(posedge mclk) disable iff (reset)
        (out_valid && !out_ready) |=> out_valid && $stable(out_data);
    endproperty
    a_hold_stall: assert property (p_hold_stall) else $error("stalled word changed or lost");

endmodule

// ### sim/atp_host_model.sv
/*
 * Host side of the register port: issues writes and reads one at a time.
 * Assumes the device takes requests on the rising edge of mclk.
 */
`timescale 1ns/1ps
module atp_host_model import atp_pkg::*; #(
    parameter int RATE_MSPS = 25
) (
    input wire logic mclk,
    output atp_regreq_s reg_req,
    input wire logic [ATP_DATA_W-1:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial reg_req = '0;

    ////////////////////////////////////////
    // released fields show inverted values so nothing leans on stale ones
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge mclk);
        reg_req = '{wr_en: 1'b1, rd_en: 1'b0, addr: addr, wdata: data};
        @(negedge mclk);
        reg_req = '{wr_en: 1'b0, rd_en: 1'b0, addr: ~addr, wdata: ~data};
    endtask

    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic rv);
        @(negedge mclk);
        reg_req = '{wr_en: 1'b0, rd_en: 1'b1, addr: addr, wdata: 8'h00};
        @(negedge mclk);
        reg_req = '{wr_en: 1'b0, rd_en: 1'b0, addr: ~addr, wdata: 8'hff};
        data = reg_rdata;
        rv = reg_rvalid;
    endtask

    task automatic set_delay_loop_pdn(input logic on);
        write_reg(OFS_SAMPLING, (on && RATE_MSPS < 40) ? 8'h04 : 8'h00);
    endtask

    // set then clear, before other writes
    task automatic fuse_load();
        write_reg(OFS_FUSE, 8'h01);
        write_reg(OFS_FUSE, 8'h00);
    endtask
endmodule

// ### sim/test_atp_test_pattern_regs.sv
/*
 * Self-checking bench of the configuration registers and pattern insertion.
 * Assumes the default auto-zero polarity and a 25 MSPS host.
 */
`timescale 1ns/1ps
module test_atp_test_pattern_regs import atp_pkg::*;;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] rexp;
    } atp_row_s;

    logic mclk = 1'b0;
    logic reset = 1'b1;
    atp_regreq_s reg_req;
    logic [7:0] reg_rdata;
    logic reg_rvalid, sample_valid = 1'b0, sample_ready, out_valid, out_ready = 1'b0;
    atp_pair_s sample_in = '0;
    atp_pair_s out_data;
    logic pdn, quarter, autozero, fsrc, fdiv, fstr, fuse_pulse;
    int errors = 0;
    int compares = 0;
    logic [7:0] rd;
    logic rv;
    logic [17:0] ea, eb;
    // reserved bits written as ones must read back zero
    atp_row_s rows[7] = '{'{8'h11, 8'hff, 8'h05}, '{8'h13, 8'hfe, 8'h00}, '{8'h14, 8'ha5, 8'ha5},
        '{8'h15, 8'h3c, 8'h3c}, '{8'h16, 8'hff, 8'hff}, '{8'h19, 8'hff, 8'h91}, '{8'h12, 8'hff, 8'h00}};

    always #12.5 mclk = ~mclk;

    atp_test_pattern_regs u_atp_test_pattern_regs (.mclk(mclk), .reset(reset), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sample_valid(sample_valid),
        .sample_ready(sample_ready), .sample_in(sample_in), .out_valid(out_valid), .out_ready(out_ready),
        .out_data(out_data), .sampling_delay_loop_powerdown(pdn), .sampling_window_quarter(quarter),
        .offset_autozero_enable(autozero), .frame_clock_source(fsrc), .frame_clock_divide(fdiv),
        .frame_clock_stretch(fstr), .fuse_map_load(fuse_pulse));
    atp_host_model u_atp_host_model (.mclk(mclk), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));

    ////////////////////////////////////////
    task automatic check_bit(input string name, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic check_reg(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_pair(input string name, input logic [35:0] exp, input logic [35:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic push(input logic [17:0] a, input logic [17:0] b);
        int n;
        @(negedge mclk);
        sample_valid = 1'b1;
        sample_in = '{chan_a: a, chan_b: b};
        for (n = 0; n < 20 && sample_ready !== 1'b1; n++) @(negedge mclk);
        @(negedge mclk);
        sample_valid = 1'b0;
        sample_in = '{chan_a: ~a, chan_b: ~b};
    endtask

    task automatic pop(input string name, input logic [17:0] a, input logic [17:0] b);
        int n;
        @(negedge mclk);
        out_ready = 1'b1;
        for (n = 0; n < 20 && out_valid !== 1'b1; n++) @(negedge mclk);
        check_pair(name, {a, b}, out_data);
        @(negedge mclk);
        out_ready = 1'b0;
    endtask

    task automatic give_verdict();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #(25ns * 6000);
        errors++;
        give_verdict();
    end

    ////////////////////////////////////////
    initial begin
        repeat (4) @(negedge mclk);
        reset = 1'b0;
        foreach (rows[i]) begin
            u_atp_host_model.read_reg(rows[i].addr, rd, rv);
            check_reg("reset value", 8'h00, rd);
        end
        check_bit("ready", 1'b1, sample_ready);
        check_bit("valid", 1'b0, out_valid);
        check_bit("quarter", 1'b1, quarter);
        check_bit("autozero", 1'b1, autozero);
        $display("reset test done");
        foreach (rows[i]) begin
            u_atp_host_model.write_reg(rows[i].addr, rows[i].wdata);
            u_atp_host_model.read_reg(rows[i].addr, rd, rv);
            check_bit("rvalid", 1'b1, rv);
            check_reg("readback", rows[i].rexp, rd);
        end
        check_bit("pdn", 1'b1, pdn);
        check_bit("quarter", 1'b0, quarter);
        check_bit("autozero", 1'b0, autozero);
        check_reg("frame", 8'h07, {5'h0, fsrc, fdiv, fstr});
        $display("register rows done");
        // every select code on both channels, user value 0x12345
        u_atp_host_model.write_reg(OFS_PAT_LOW, 8'h45);
        u_atp_host_model.write_reg(OFS_PAT_MID, 8'h23);
        for (int c = 0; c < 8; c++) begin
            u_atp_host_model.write_reg(OFS_PAT_SEL_HIGH, {c[2:0], c[2:0], 2'b01});
            ea = (c == 3) ? 18'h12345 : (c == 2) ? 18'h0 : 18'h1abcd;
            eb = (c == 3) ? 18'h12345 : (c == 2) ? 18'h0 : 18'h02468;
            push(18'h1abcd, 18'h02468);
            pop("select code", ea, eb);
        end
        // one channel constant, the other passing through
        u_atp_host_model.write_reg(OFS_PAT_SEL_HIGH, 8'h62);
        push(18'h00fff, 18'h3f000);
        pop("mixed", 18'h00fff, 18'h22345);
        $display("pattern codes done");
        // step of 0x21, then a step of 0x20000 that wraps
        for (int s = 0; s < 2; s++) begin
            u_atp_host_model.write_reg(OFS_PAT_SEL_HIGH, 8'h00);
            u_atp_host_model.write_reg(OFS_PAT_LOW, s ? 8'h00 : 8'h21);
            u_atp_host_model.write_reg(OFS_PAT_MID, 8'h00);
            u_atp_host_model.write_reg(OFS_PAT_SEL_HIGH, s ? 8'h4a : 8'h48);
            for (int k = 0; k < 3; k++) begin
                ea = s ? ((k == 1) ? 18'h20000 : 18'h0) : 18'(k * 33);
                push(18'h1, 18'h2);
                pop("ramp", ea, ea);
            end
        end
        $display("ramp done");
        // stall: two words fill the buffer, then drain in order
        u_atp_host_model.write_reg(OFS_PAT_SEL_HIGH, 8'h00);
        push(18'h11111, 18'h22222);
        push(18'h33333, 18'h04444);
        @(negedge mclk);
        check_bit("full ready", 1'b0, sample_ready);
        pop("drain first", 18'h11111, 18'h22222);
        pop("drain second", 18'h33333, 18'h04444);
        check_bit("empty valid", 1'b0, out_valid);
        $display("buffer done");
        // fuse load clears earlier writes and pulses once
        u_atp_host_model.set_delay_loop_pdn(1'b1);
        u_atp_host_model.write_reg(OFS_PAT_LOW, 8'h55);
        check_bit("pulse early", 1'b0, fuse_pulse);
        u_atp_host_model.fuse_load();
        // strobe rises at the edge that takes the zero write
        check_bit("pulse", 1'b1, fuse_pulse);
        @(negedge mclk);
        check_bit("pulse end", 1'b0, fuse_pulse);
        check_bit("pdn cleared", 1'b0, pdn);
        u_atp_host_model.read_reg(OFS_PAT_LOW, rd, rv);
        check_reg("low cleared", 8'h00, rd);
        $display("fuse load done");
        give_verdict();
    end
endmodule
